// ===== design/capture_reg.sv
`timescale 1ns/100ps
`default_nettype none
module capture_reg #(
	parameter int W = 32
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] q_next;

	always_comb begin
		q_next = load ? d : q;
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= q_next;
		end
	end
endmodule // capture_reg
`default_nettype wire

// ===== design/ctrl_word_decode.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_word_decode
	import txd_pkg::*;
(
	input  wire logic [31:0]      tx_desc_ctrl_word,
	output var  logic             first_seg_flag,
	output var  logic             crc_append_off,
	output var  logic             ring_end_flag,
	output var  logic             chained_next_flag,
	output var  logic             chain_eff,
	output var  logic             pad_off,
	output var  logic [LEN_W-1:0] buf_one_len,
	output var  logic [LEN_W-1:0] buf_two_len
);
	// reserved bit 22 is never looked at
	always_comb begin
		first_seg_flag    = tx_desc_ctrl_word[FIRST_SEG_BIT];
		crc_append_off    = tx_desc_ctrl_word[CRC_OFF_BIT];
		ring_end_flag     = tx_desc_ctrl_word[RING_END_BIT];
		chained_next_flag = tx_desc_ctrl_word[CHAIN_BIT];
		chain_eff         = chained_next_flag & ~ring_end_flag;
		pad_off           = tx_desc_ctrl_word[PAD_OFF_BIT];
		buf_two_len       = tx_desc_ctrl_word[LEN2_HI:LEN2_LO];
		buf_one_len       = tx_desc_ctrl_word[LEN1_HI:LEN1_LO];
	end
endmodule // ctrl_word_decode
`default_nettype wire

// ===== design/tx_descriptor_interpreter.sv
// Contract
// - crc-append-off suppresses crc, honoured only on a first-segment descriptor
// - after a ring-end descriptor the next fetch comes from the list base
// - chained flag makes the fourth word the next descriptor address
// - ring-end overrides chained; fourth word then points at buffer two
// - first segment without pad-off: pad below 64 bytes and force crc; code sets frame_pad_en, but frame_crc_off still follows crc-append-off
// - bits 21:11 give buffer-two length, disregarded when chained
// - bits 10:0 give buffer-one length; zero skips buffer one
// - third word is buffer-one address, any byte alignment
// - without chaining fourth word is buffer-two address, any alignment
// - reserved bit 22 ignored; control word never written back
// - bit 29 marks first segment and qualifies per-frame options
// - on entering running the first fetch comes from the list base
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module tx_descriptor_interpreter
	import txd_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [3:0]       addr,
	input  wire logic [31:0]      wdata,
	input  wire logic             wr,
	input  wire logic             rd,
	output var  logic [31:0]      rdata,
	output var  logic             mem_rd,
	output var  logic [31:0]      mem_addr,
	input  wire logic             mem_rvalid,
	input  wire logic [31:0]      mem_rdata,
	output var  logic             xfer_valid,
	output var  logic [31:0]      xfer_addr,
	output var  logic [LEN_W-1:0] xfer_len,
	output var  logic             xfer_first,
	input  wire logic             xfer_done,
	output var  logic             frame_crc_off,
	output var  logic             frame_pad_en
);
	// ****************************************
	// declarations
	// ****************************************
	eng_state_t       state_reg, state_next;
	logic [1:0]       idx_reg, idx_next;
	logic [31:0]      cur_reg, cur_next;
	logic             fetched_reg, fetched_next;
	logic [15:0]      cnt_reg, cnt_next;
	logic             mem_rd_next;
	logic [31:0]      mem_addr_next;
	logic             xv_next;
	logic [31:0]      xa_next;
	logic [LEN_W-1:0] xl_next;
	logic             xf_next;
	logic             fco_next, fpe_next;
	logic [31:0]      base_reg, base_next;
	logic             run_reg, run_next;
	logic [31:0]      rdata_next;
	logic [31:0]      ctrl_w, ptr1_w, ptr2_w;
	logic             ld_ctrl, ld_ptr1, ld_ptr2;
	logic             fs, cao, re, ch, ch_eff, po;
	logic [LEN_W-1:0] len1, len2;

	// ****************************************
	// descriptor word capture
	// ****************************************
	assign ld_ctrl = (state_reg == ST_WAIT) && mem_rvalid && (idx_reg == WORD_CTRL);
	assign ld_ptr1 = (state_reg == ST_WAIT) && mem_rvalid && (idx_reg == WORD_PTR1);
	assign ld_ptr2 = (state_reg == ST_WAIT) && mem_rvalid && (idx_reg == WORD_PTR2);

	capture_reg #(.W(32)) u_ctrl (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.load    (ld_ctrl),
		.d       (mem_rdata),
		.q       (ctrl_w)
	);
	capture_reg #(.W(32)) u_ptr1 (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.load    (ld_ptr1),
		.d       (mem_rdata),
		.q       (ptr1_w)
	);
	capture_reg #(.W(32)) u_ptr2 (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.load    (ld_ptr2),
		.d       (mem_rdata),
		.q       (ptr2_w)
	);

	ctrl_word_decode u_dec (
		.tx_desc_ctrl_word (ctrl_w),
		.first_seg_flag    (fs),
		.crc_append_off    (cao),
		.ring_end_flag     (re),
		.chained_next_flag (ch),
		.chain_eff         (ch_eff),
		.pad_off           (po),
		.buf_one_len       (len1),
		.buf_two_len       (len2)
	);

	// ****************************************
	// register port
	// ****************************************
	always_comb begin
		base_next  = base_reg;
		run_next   = run_reg;
		rdata_next = 32'h0000_0000;
		if (wr) begin
			unique case (addr)
				REG_RUN_CTRL: run_next  = wdata[RUN_BIT];
				REG_TX_BASE:  base_next = wdata;
				default:      ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				REG_RUN_CTRL: rdata_next = {31'h0, run_reg};
				REG_TX_BASE:  rdata_next = base_reg;
				REG_STATUS:   rdata_next = {cnt_reg, 14'h0, fetched_reg,
					(state_reg != ST_IDLE)};
				REG_CUR_DESC: rdata_next = cur_reg;
				default:      rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			base_reg <= TX_BASE_RST;
			run_reg  <= 1'b0;
			rdata    <= 32'h0000_0000;
		end else begin
			base_reg <= base_next;
			run_reg  <= run_next;
			rdata    <= rdata_next;
		end
	end

	// ****************************************
	// descriptor engine
	// ****************************************
	// nothing here ever drives a write toward memory
	always_comb begin
		state_next    = state_reg;
		idx_next      = idx_reg;
		cur_next      = cur_reg;
		fetched_next  = fetched_reg;
		cnt_next      = cnt_reg;
		mem_rd_next   = 1'b0;
		mem_addr_next = mem_addr;
		xv_next       = xfer_valid;
		xa_next       = xfer_addr;
		xl_next       = xfer_len;
		xf_next       = xfer_first;
		fco_next      = frame_crc_off;
		fpe_next      = frame_pad_en;
		unique case (state_reg)
			ST_IDLE: begin
				if (run_reg) begin
					cur_next   = base_reg;
					idx_next   = WORD_CTRL;
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				mem_rd_next   = 1'b1;
				mem_addr_next = cur_reg + {28'h0, idx_reg, 2'b00};
				state_next    = ST_WAIT;
			end
			ST_WAIT: begin
				if (mem_rvalid) begin
					if (idx_reg == WORD_PTR2) begin
						fetched_next = 1'b1;
						state_next   = ST_BUF1;
					end else begin
						idx_next   = idx_reg + 2'h1;
						state_next = ST_FETCH;
					end
				end
			end
			ST_BUF1: begin
				if (fs) begin
					fco_next = cao;
					fpe_next = ~po;
				end
				if (xfer_valid) begin
					if (xfer_done) begin
						xv_next    = 1'b0;
						state_next = ST_BUF2;
					end
				end else if (len1 != '0) begin
					xv_next = 1'b1;
					xa_next = ptr1_w;
					xl_next = len1;
					xf_next = fs;
				end else begin
					state_next = ST_BUF2;
				end
			end
			ST_BUF2: begin
				if (xfer_valid) begin
					if (xfer_done) begin
						xv_next    = 1'b0;
						state_next = ST_NEXT;
					end
				end else if (!ch_eff && (len2 != '0)) begin
					xv_next = 1'b1;
					xa_next = ptr2_w;
					xl_next = len2;
					xf_next = fs && (len1 == '0);
				end else begin
					state_next = ST_NEXT;
				end
			end
			ST_NEXT: begin
				fetched_next = 1'b0;
				cnt_next     = cnt_reg + 16'h1;
				if (re) begin
					cur_next = base_reg;
				end else if (ch_eff) begin
					cur_next = ptr2_w;
				end else begin
					cur_next = cur_reg + DESC_STRIDE;
				end
				idx_next   = WORD_CTRL;
				state_next = run_reg ? ST_FETCH : ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg     <= ST_IDLE;
			idx_reg       <= WORD_CTRL;
			cur_reg       <= TX_BASE_RST;
			fetched_reg   <= 1'b0;
			cnt_reg       <= 16'h0000;
			mem_rd        <= 1'b0;
			mem_addr      <= 32'h0000_0000;
			xfer_valid    <= 1'b0;
			xfer_addr     <= 32'h0000_0000;
			xfer_len      <= '0;
			xfer_first    <= 1'b0;
			frame_crc_off <= 1'b0;
			frame_pad_en  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			idx_reg       <= idx_next;
			cur_reg       <= cur_next;
			fetched_reg   <= fetched_next;
			cnt_reg       <= cnt_next;
			mem_rd        <= mem_rd_next;
			mem_addr      <= mem_addr_next;
			xfer_valid    <= xv_next;
			xfer_addr     <= xa_next;
			xfer_len      <= xl_next;
			xfer_first    <= xf_next;
			frame_crc_off <= fco_next;
			frame_pad_en  <= fpe_next;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	AST_FETCH_FIRST: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(xfer_valid) |-> fetched_reg)
		else $error("transfer started before descriptor fetched");

	AST_START_BASE: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_IDLE) && run_reg |=> (cur_reg == $past(base_reg))
			&& (state_reg == ST_FETCH) ##1 (mem_addr == cur_reg + {28'h0, WORD_CTRL, 2'b00}))
		else $error("first fetch not from list base");

	AST_RING_WRAP: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_NEXT) && re |=> (cur_reg == $past(base_reg)))
		else $error("ring end did not wrap to base");

	AST_NEXT_STRIDE: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_NEXT) && !re && !ch_eff |=> (cur_reg == $past(cur_reg) + DESC_STRIDE))
		else $error("plain descriptor did not advance by one stride");

	AST_CHAIN_NEXT: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_NEXT) && ch && !re |=> (cur_reg == $past(ptr2_w)))
		else $error("chained pointer not followed");

	AST_RING_OVER_CHAIN: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF2) && re && ch && (len2 != '0) && !xfer_valid
		|=> xfer_valid && (xfer_addr == ptr2_w))
		else $error("ring end did not use buffer two");

	AST_NO_BUF2_CHAIN: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF2) && ch_eff |=> !xfer_valid)
		else $error("buffer two used while chained");

	AST_LEN1_SKIP: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF1) && !xfer_valid && (len1 == '0)
		|=> (state_reg == ST_BUF2) && !xfer_valid)
		else $error("zero length buffer one not skipped");

	AST_FIRST_IN_BUF2: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF2) && $rose(xfer_valid) && fs && (len1 == '0) |-> xfer_first)
		else $error("buffer two not marked as frame start after skip");

	AST_BUF1_ISSUE: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF1) && !xfer_valid && (len1 != '0)
		|=> xfer_valid && (xfer_addr == ptr1_w) && (xfer_len == len1)
			&& (xfer_addr[1:0] == ptr1_w[1:0]))
		else $error("buffer one request wrong");

	AST_BUF2_ADDR: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF2) && $rose(xfer_valid) |-> (xfer_addr == ptr2_w))
		else $error("buffer two address wrong");

	AST_FRAME_OPTS: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF1) && fs |=> (frame_crc_off == $past(cao))
			&& (frame_pad_en == !$past(po)))
		else $error("frame options not taken from first segment");

	AST_OPTS_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF1) && !fs |=> $stable(frame_crc_off)
			&& $stable(frame_pad_en))
		else $error("frame options changed on middle segment");

	AST_READ_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
		mem_rd |-> (state_reg == ST_WAIT) ##1 !mem_rd [*1])
		else $error("memory access outside fetch");

	COV_CHAIN: cover property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_NEXT) && ch_eff);
	COV_RING: cover property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_NEXT) && re && ch);
	COV_SKIP1: cover property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF1) && (len1 == '0) && fs);
	COV_TWO_BUFS: cover property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF2) && $rose(xfer_valid));
	COV_PAD_OFF: cover property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_BUF1) && fs && po);
endmodule // tx_descriptor_interpreter
`default_nettype wire

// ===== design/txd_pkg.sv
package txd_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0]  REG_RUN_CTRL    = 4'h0;
	localparam logic [3:0]  REG_TX_BASE     = 4'h4;
	localparam logic [3:0]  REG_STATUS      = 4'h8;
	localparam logic [3:0]  REG_CUR_DESC    = 4'hC;
	localparam int          RUN_BIT         = 0;
	localparam logic [31:0] TX_BASE_RST     = 32'h0000_0000;
	// ****************************************
	// descriptor layout
	// ****************************************
	localparam logic [1:0]  WORD_CTRL       = 2'h1;
	localparam logic [1:0]  WORD_PTR1       = 2'h2;
	localparam logic [1:0]  WORD_PTR2       = 2'h3;
	localparam logic [31:0] DESC_STRIDE     = 32'h0000_0010;
	localparam int          FIRST_SEG_BIT   = 29;
	localparam int          CRC_OFF_BIT     = 26;
	localparam int          RING_END_BIT    = 25;
	localparam int          CHAIN_BIT       = 24;
	localparam int          PAD_OFF_BIT     = 23;
	localparam int          LEN2_HI         = 21;
	localparam int          LEN2_LO         = 11;
	localparam int          LEN1_HI         = 10;
	localparam int          LEN1_LO         = 0;
	localparam int          LEN_W           = 11;
	localparam int          MIN_FRAME_BYTES = 64;
	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_WAIT, ST_BUF1, ST_BUF2, ST_NEXT
	} eng_state_t;
endpackage : txd_pkg

// ===== dv/tx_desc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module tx_desc_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        mem_rd,
	input  wire logic [31:0] mem_addr,
	output var  logic        mem_rvalid,
	output var  logic [31:0] mem_rdata
);
	// ****************************************
	// host memory, filled by the bench
	// ****************************************
	logic [31:0] mem [logic [31:0]];
	logic [31:0] req_addr;
	logic [31:0] last_data;
	int          wait_cnt;
	logic        slow;
	// ****************************************
	// answers alternate fast and slow; words served unaltered
	// ****************************************
	always @(posedge ref_clk) begin
		mem_rvalid <= 1'b0;
		mem_rdata  <= ~last_data;
		if (!rstn) begin
			wait_cnt  <= 0;
			slow      <= 1'b0;
			last_data <= 32'h0000_0000;
		end else if (mem_rd === 1'b1) begin
			req_addr <= mem_addr;
			wait_cnt <= slow ? 3 : 1;
			slow     <= ~slow;
		end else if (wait_cnt > 1) begin
			wait_cnt <= wait_cnt - 1;
		end else if (wait_cnt == 1) begin
			wait_cnt   <= 0;
			mem_rvalid <= 1'b1;
			mem_rdata  <= mem.exists(req_addr) ? mem[req_addr] : 32'h0000_0000;
			last_data  <= mem.exists(req_addr) ? mem[req_addr] : 32'h0000_0000;
		end
	end
endmodule // tx_desc_mem_model
`default_nettype wire

// ===== dv/tx_descriptor_interpreter_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tx_descriptor_interpreter_tb_top
	import txd_pkg::*;
;
	logic             ref_clk, rstn, wr, rd, mem_rd, mem_rvalid, xfer_valid;
	logic             xfer_first, xfer_done, frame_crc_off, frame_pad_en;
	logic [3:0]       addr;
	logic [31:0]      wdata, rdata, mem_addr, mem_rdata, xfer_addr, rv;
	logic [LEN_W-1:0] xfer_len;
	logic [31:0]      fetch_q [$];
	logic [31:0]      bases [5] = '{32'h100, 32'h110, 32'h120, 32'h200, 32'h100};
	int               n_fail, compares;

	tx_descriptor_interpreter dut_u (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.xfer_valid(xfer_valid), .xfer_addr(xfer_addr), .xfer_len(xfer_len),
		.xfer_first(xfer_first), .xfer_done(xfer_done),
		.frame_crc_off(frame_crc_off), .frame_pad_en(frame_pad_en));
	tx_desc_mem_model mem_u (.ref_clk(ref_clk), .rstn(rstn), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

	// ****************************************
	// clock, fetch monitor, watchdog
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (rstn === 1'b1 && mem_rd === 1'b1) fetch_q.push_back(mem_addr);
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		$display("MISMATCH run_time exp done seen hang");
		results();
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [31:0] ctl(input logic fs, crc, re, ch, po,
		input logic [10:0] l2, l1);
		return {2'b00, fs, 2'b00, crc, re, ch, po, 1'b0, l2, l1};
	endfunction
	task automatic put_desc(input logic [31:0] d, c, p1, p2);
		mem_u.mem[d + 32'h4] = c;
		mem_u.mem[d + 32'h8] = p1;
		mem_u.mem[d + 32'hC] = p2;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic exp_xfer(input logic [31:0] a, input logic [10:0] len,
		input logic first, crc_off, pad_en);
		for (int i = 0; i < 400 && xfer_valid !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (xfer_valid !== 1'b1) begin
			n_fail++;
			$display("MISMATCH xfer_valid exp 1 seen 0");
			results();
		end
		check("fetch_count_mod3", 0, 32'(fetch_q.size() % 3));
		check("xfer_addr", a, xfer_addr);
		check("xfer_len", 32'(len), 32'(xfer_len));
		check("xfer_first", 32'(first), 32'(xfer_first));
		check("frame_crc_off", 32'(crc_off), 32'(frame_crc_off));
		check("frame_pad_en", 32'(pad_en), 32'(frame_pad_en));
		repeat (2) @(posedge ref_clk);
		xfer_done <= 1'b1;
		@(posedge ref_clk);
		xfer_done <= 1'b0;
		#1 check("xfer_valid_drop", 0, 32'(xfer_valid));
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		n_fail = 0;
		compares = 0;
		{rstn, wr, rd, xfer_done, addr, wdata} = '0;
		put_desc(32'h100, ctl(1, 1, 0, 0, 0, 7, 5), 32'h1003, 32'h2001);
		put_desc(32'h110, ctl(1, 1, 0, 0, 1, 9, 0), 32'h1100, 32'h2102);
		put_desc(32'h120, ctl(0, 0, 0, 1, 0, 0, 4), 32'h1207, 32'h0200);
		put_desc(32'h200, ctl(1, 0, 1, 1, 1, 6, 3), 32'h1301, 32'h3005);
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		rd_reg(REG_RUN_CTRL, rv);
		check("run_reset", 0, rv);
		rd_reg(REG_TX_BASE, rv);
		check("base_reset", TX_BASE_RST, rv);
		rd_reg(4'h2, rv);
		check("unmapped", 0, rv);
		wr_reg(REG_TX_BASE, 32'h100);
		rd_reg(REG_TX_BASE, rv);
		check("base_rw", 32'h100, rv);
		wr_reg(REG_RUN_CTRL, 32'h1);
		exp_xfer(32'h1003, 5, 1, 1, 1);
		exp_xfer(32'h2001, 7, 0, 1, 1);
		exp_xfer(32'h2102, 9, 1, 1, 0);
		exp_xfer(32'h1207, 4, 0, 1, 0);
		exp_xfer(32'h1301, 3, 1, 0, 0);
		exp_xfer(32'h3005, 6, 0, 0, 0);
		wr_reg(REG_RUN_CTRL, 32'h0);
		exp_xfer(32'h1003, 5, 1, 1, 1);
		exp_xfer(32'h2001, 7, 0, 1, 1);
		rv = 32'h1;
		for (int i = 0; i < 50 && rv[0] !== 1'b0; i++) rd_reg(REG_STATUS, rv);
		check("busy_after_stop", 0, 32'(rv[0]));
		check("fetched_after_stop", 0, 32'(rv[1]));
		check("serviced_count", 5, 32'(rv[31:16]));
		rd_reg(REG_CUR_DESC, rv);
		check("cur_desc", 32'h110, rv);
		check("fetch_total", 15, 32'(fetch_q.size()));
		for (int j = 0; j < 5; j++) begin
			for (int k = 0; k < 3 && 3 * j + k < fetch_q.size(); k++) begin
				check("fetch_addr", bases[j] + 32'(4 * k + 4), fetch_q[3 * j + k]);
			end
		end
		results();
	end
endmodule // tx_descriptor_interpreter_tb_top
`default_nettype wire
